// >>> shared/duis_consts.vh
// constants for the dual-channel interrupt status block
`ifndef DUIS_CONSTS_VH
`define DUIS_CONSTS_VH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define DUIS_OFF_STATUS     12'h000
`define DUIS_OFF_MASK       12'h004
`define DUIS_OFF_MODE_A     12'h008
`define DUIS_OFF_MODE_B     12'h00C
`define DUIS_OFF_COMMAND    12'h010
`define DUIS_OFF_TIMER      12'h014
`define DUIS_OFF_CHANGE     12'h018
`define DUIS_OFF_LEVELS     12'h01C

// ----------------------------------------------------------------------------
// status bit positions
// ----------------------------------------------------------------------------
`define DUIS_BIT_TX_A       0
`define DUIS_BIT_RX_A       1
`define DUIS_BIT_BRK_A      2
`define DUIS_BIT_CTR        3
`define DUIS_BIT_TX_B       4
`define DUIS_BIT_RX_B       5
`define DUIS_BIT_BRK_B      6
`define DUIS_BIT_IPC        7

// ----------------------------------------------------------------------------
// command register codes, mode register tx level field and timer mode bit
// ----------------------------------------------------------------------------
`define DUIS_CMD_RST_BRK_A  8'h01
`define DUIS_CMD_RST_BRK_B  8'h02
`define DUIS_CMD_START_CT   8'h03
`define DUIS_CMD_STOP_CT    8'h04
`define DUIS_TXLVL_HI       5
`define DUIS_TXLVL_LO       4
`define DUIS_TIMER_MODE_BIT 16

// ----------------------------------------------------------------------------
// reset values and fifo depth
// ----------------------------------------------------------------------------
`define DUIS_RST_STATUS     8'h00
`define DUIS_RST_MASK       8'h00
`define DUIS_RST_MODE       8'h00
`define DUIS_RST_TIMER      17'h00002
`define DUIS_FIFO_DEPTH     16

`endif

// >>> logic/duis_level_cmp.v
// transmit interrupt level comparator for one channel
`timescale 1ns/1ps
module duis_level_cmp #(
    parameter DEPTH = 16
) (
    input  wire       hclk,
    input  wire       hresetn,
    input  wire [1:0] level_sel,
    input  wire [4:0] tx_free,
    output reg        tx_irq_q
);
    reg [4:0] thr_d;

    // level code picks how many free slots raise the request
    always @* begin
        case (level_sel)
            2'b00:   thr_d = DEPTH[4:0];
            2'b01:   thr_d = DEPTH[4:0] >> 1;
            2'b10:   thr_d = DEPTH[4:0] >> 2;
            default: thr_d = 5'h01;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_irq_q <= 1'b0;
        end else begin
            tx_irq_q <= (tx_free >= thr_d);
        end
    end
endmodule // duis_level_cmp

// >>> logic/duis_top.v
// interrupt status collection with ahb-lite register slave
`timescale 1ns/1ps
`include "duis_consts.vh"
module duis_top #(
    parameter DEPTH = `DUIS_FIFO_DEPTH
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [11:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire        brk_edge_a,
    input  wire        brk_edge_b,
    input  wire        rx_lvl_a,
    input  wire        rx_lvl_b,
    input  wire        rx_wdog_a,
    input  wire        rx_wdog_b,
    input  wire [4:0]  tx_free_a,
    input  wire [4:0]  tx_free_b,
    input  wire        ip_change,
    output reg         irq_out_n,
    output reg  [7:0]  interrupt_status
);
    // ------------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------------
    reg        ph_q;
    reg        ph_wr_q;
    reg [11:0] ph_addr_q;
    wire       take = hsel & hready & htrans[1];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_q      <= 1'b0;
            ph_wr_q   <= 1'b0;
            ph_addr_q <= 12'h000;
        end else if (hready) begin
            ph_q      <= take;
            ph_wr_q   <= hwrite;
            ph_addr_q <= haddr;
        end
    end

    wire wr = ph_q & ph_wr_q;
    wire rd_take = take & ~hwrite;

    // ------------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------------
    reg [7:0]  interrupt_mask_q;
    reg [7:0]  mode_reg_zero_a_q;
    reg [7:0]  mode_reg_zero_b_q;
    reg [16:0] timer_cfg_q;
    reg [7:0]  input_change_register_q;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            interrupt_mask_q  <= `DUIS_RST_MASK;
            mode_reg_zero_a_q <= `DUIS_RST_MODE;
            mode_reg_zero_b_q <= `DUIS_RST_MODE;
            timer_cfg_q       <= `DUIS_RST_TIMER;
        end else if (wr) begin
            case (ph_addr_q)
                `DUIS_OFF_MASK:   interrupt_mask_q  <= hwdata[7:0];
                `DUIS_OFF_MODE_A: mode_reg_zero_a_q <= hwdata[7:0];
                `DUIS_OFF_MODE_B: mode_reg_zero_b_q <= hwdata[7:0];
                `DUIS_OFF_TIMER:  timer_cfg_q       <= hwdata[16:0];
                default: ;
            endcase
        end
    end

    wire cmd_wr  = wr & (ph_addr_q == `DUIS_OFF_COMMAND);
    wire cmd_rba = cmd_wr & (hwdata[7:0] == `DUIS_CMD_RST_BRK_A);
    wire cmd_rbb = cmd_wr & (hwdata[7:0] == `DUIS_CMD_RST_BRK_B);
    wire cmd_sta = cmd_wr & (hwdata[7:0] == `DUIS_CMD_START_CT);
    wire cmd_stp = cmd_wr & (hwdata[7:0] == `DUIS_CMD_STOP_CT);
    // change register read is taken at the address phase
    wire ipc_rd  = rd_take & (haddr == `DUIS_OFF_CHANGE);

    // ------------------------------------------------------------------------
    // counter/timer
    // ------------------------------------------------------------------------
    reg [15:0] ct_q;
    reg        ct_run_q;
    reg        ct_half_q;
    wire       timer_mode = timer_cfg_q[`DUIS_TIMER_MODE_BIT];
    wire       ct_zero    = ct_run_q & (ct_q == 16'h0000);
    reg        ct_event;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ct_q      <= 16'h0000;
            ct_run_q  <= 1'b0;
            ct_half_q <= 1'b0;
        end else if (cmd_sta) begin
            ct_q      <= timer_cfg_q[15:0];
            ct_run_q  <= 1'b1;
            ct_half_q <= 1'b0;
        end else if (ct_run_q) begin
            if (timer_mode && ct_zero) begin
                ct_q      <= timer_cfg_q[15:0] - 16'h0001;
                ct_half_q <= ~ct_half_q;
            end else begin
                // counter wraps past terminal count
                ct_q <= ct_q - 16'h0001;
            end
            if (!timer_mode && cmd_stp) begin
                ct_run_q <= 1'b0;
            end
        end
    end

    always @* begin
        if (timer_mode) begin
            ct_event = ct_zero & ct_half_q;
        end else begin
            ct_event = ct_zero;
        end
    end

    // ------------------------------------------------------------------------
    // transmit level comparators
    // ------------------------------------------------------------------------
    wire tx_irq_chan_a;
    wire tx_irq_chan_b;

    duis_level_cmp #(.DEPTH(DEPTH)) u_lvl_a (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .level_sel (mode_reg_zero_a_q[`DUIS_TXLVL_HI:`DUIS_TXLVL_LO]),
        .tx_free   (tx_free_a),
        .tx_irq_q  (tx_irq_chan_a)
    );

    duis_level_cmp #(.DEPTH(DEPTH)) u_lvl_b (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .level_sel (mode_reg_zero_b_q[`DUIS_TXLVL_HI:`DUIS_TXLVL_LO]),
        .tx_free   (tx_free_b),
        .tx_irq_q  (tx_irq_chan_b)
    );

    // ------------------------------------------------------------------------
    // status collection
    // ------------------------------------------------------------------------
    reg [7:0] st_d;

    always @* begin
        st_d = interrupt_status;
        // rx bits from fill or watchdog, not ready flag
        st_d[`DUIS_BIT_RX_A] = rx_lvl_a | rx_wdog_a;
        st_d[`DUIS_BIT_RX_B] = rx_lvl_b | rx_wdog_b;
        st_d[`DUIS_BIT_TX_A] = tx_irq_chan_a;
        st_d[`DUIS_BIT_TX_B] = tx_irq_chan_b;
        // clear by own command, bit 7 by change register read; set wins
        if (cmd_rba) begin
            st_d[`DUIS_BIT_BRK_A] = 1'b0;
        end
        if (cmd_rbb) begin
            st_d[`DUIS_BIT_BRK_B] = 1'b0;
        end
        if (brk_edge_a) begin
            st_d[`DUIS_BIT_BRK_A] = 1'b1;
        end
        if (brk_edge_b) begin
            st_d[`DUIS_BIT_BRK_B] = 1'b1;
        end
        if (cmd_stp) begin
            st_d[`DUIS_BIT_CTR] = 1'b0;
        end
        if (ct_event) begin
            st_d[`DUIS_BIT_CTR] = 1'b1;
        end
        if (ipc_rd) begin
            st_d[`DUIS_BIT_IPC] = 1'b0;
        end
        if (ip_change) begin
            st_d[`DUIS_BIT_IPC] = 1'b1;
        end
    end

    // zero at reset; status read has no side effect
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            interrupt_status        <= `DUIS_RST_STATUS;
            input_change_register_q <= 8'h00;
        end else begin
            interrupt_status <= st_d;
            if (ipc_rd) begin
                input_change_register_q <= {7'h00, ip_change};
            end else if (ip_change) begin
                input_change_register_q <= 8'h01;
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_out_n <= 1'b1;
        end else begin
            irq_out_n <= ~|(st_d & interrupt_mask_q);
        end
    end

    // ------------------------------------------------------------------------
    // read data, registered at address phase
    // ------------------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (rd_take) begin
                case (haddr)
                    `DUIS_OFF_STATUS: hrdata <= {24'h000000, interrupt_status};
                    `DUIS_OFF_MASK:   hrdata <= {24'h000000, interrupt_mask_q};
                    `DUIS_OFF_MODE_A: hrdata <= {24'h000000, mode_reg_zero_a_q};
                    `DUIS_OFF_MODE_B: hrdata <= {24'h000000, mode_reg_zero_b_q};
                    `DUIS_OFF_TIMER:  hrdata <= {15'h0000, timer_cfg_q};
                    `DUIS_OFF_CHANGE: hrdata <= {24'h000000, input_change_register_q};
                    `DUIS_OFF_LEVELS: hrdata <= {16'h0000, ct_q};
                    default:          hrdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // duis_top

// >>> sim/duis_checker.sv
// port-level assertions for the interrupt status block
`timescale 1ns/1ps
`include "duis_consts.vh"
module duis_checker #(
    parameter DEPTH = 16
) (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [11:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire [31:0] hwdata,
    input wire        brk_edge_a,
    input wire        brk_edge_b,
    input wire        rx_lvl_a,
    input wire        rx_wdog_a,
    input wire        ip_change,
    input wire        irq_out_n,
    input wire [7:0]  interrupt_status
);
    reg cmd_q;
    // command write now in its data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_q <= 1'b0;
        end else begin
            cmd_q <= hsel & hready & htrans[1] & hwrite & (haddr == `DUIS_OFF_COMMAND);
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_clr_a;
        cmd_q && hwdata[7:0] == `DUIS_CMD_RST_BRK_A && !brk_edge_a;
    endsequence
    property p_brk_a; brk_edge_a |=> interrupt_status[2]; endproperty
    property p_brk_b; brk_edge_b |=> interrupt_status[6]; endproperty
    property p_brk_clr; s_clr_a |=> !interrupt_status[2]; endproperty
    property p_brk_hold; interrupt_status[6] && !cmd_q |=> interrupt_status[6]; endproperty
    property p_ctr_hold; interrupt_status[3] && !cmd_q |=> interrupt_status[3]; endproperty
    property p_rx_a; 1'b1 |=> interrupt_status[1] == $past(rx_lvl_a | rx_wdog_a); endproperty
    property p_ipc; ip_change |=> interrupt_status[7]; endproperty
    property p_irq_idle; interrupt_status == 8'h00 |-> irq_out_n; endproperty
    a_brk_a: assert property (p_brk_a) else $error("break A edge missed");
    a_brk_b: assert property (p_brk_b) else $error("break B edge missed");
    a_brk_clr: assert property (p_brk_clr) else $error("break A not cleared");
    a_brk_hold: assert property (p_brk_hold) else $error("break B lost");
    a_ctr_hold: assert property (p_ctr_hold) else $error("counter ready lost");
    a_rx_a: assert property (p_rx_a) else $error("rx A bit wrong");
    a_ipc: assert property (p_ipc) else $error("input change missed");
    a_irq_idle: assert property (p_irq_idle) else $error("irq without status");
endmodule // duis_checker

bind duis_top duis_checker #(.DEPTH(DEPTH)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .brk_edge_a(brk_edge_a),
    .brk_edge_b(brk_edge_b), .rx_lvl_a(rx_lvl_a), .rx_wdog_a(rx_wdog_a),
    .ip_change(ip_change), .irq_out_n(irq_out_n), .interrupt_status(interrupt_status)
);

// >>> sim/duis_host.sv
// ahb-lite host model issuing single word transfers
`timescale 1ns/1ps
module duis_host (
    input  wire logic        hclk,
    input  wire logic        hready,
    output logic             hsel = 1'b0,
    output logic [11:0]      haddr = 12'h000,
    output logic [1:0]       htrans = 2'h0,
    output logic             hwrite = 1'b0,
    output logic [2:0]       hsize = 3'h2,
    output logic [31:0]      hwdata = 32'h0
);
    int hangs = 0;
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
        // released data must not look valid
        hwdata <= ~wd;
        if (n >= 100) begin
            hangs++;
        end
    endtask
endmodule // duis_host

// >>> sim/duart_interrupt_status_tb.sv
// self-checking bench for the interrupt status block
`timescale 1ns/1ps
`include "duis_consts.vh"
module duart_interrupt_status_tb;
    logic        hclk = 1'b0;
    logic        hresetn, hsel, hwrite, hready, hreadyout, hresp, irq_out_n;
    logic        rd_ph = 1'b0;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize, pls;
    logic [31:0] hwdata, hrdata;
    logic [3:0]  rxl;
    logic [4:0]  txa, txb;
    logic [7:0]  st, mask, interrupt_status;
    logic [32:0] note;
    logic [32:0] exp_q[$];
    logic [31:0] rnd = 32'h0000000B;
    logic [4:0]  thr[4] = '{5'h10, 5'h08, 5'h04, 5'h01};
    int          errors = 0;
    int          comparisons = 0;
    assign hready = hreadyout;
    initial forever #2 hclk = ~hclk;
    duis_host u_host (.hclk(hclk), .hready(hready), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    duis_top #(.DEPTH(16)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .brk_edge_a(pls[0]), .brk_edge_b(pls[1]),
        .rx_lvl_a(rxl[0]), .rx_lvl_b(rxl[1]), .rx_wdog_a(rxl[2]), .rx_wdog_b(rxl[3]),
        .tx_free_a(txa), .tx_free_b(txb), .ip_change(pls[2]), .irq_out_n(irq_out_n),
        .interrupt_status(interrupt_status));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back({~|(st & mask), e});
        u_host.xfer(1'b0, a, 32'h0);
    endtask
    task automatic rd_st(input logic [7:0] e);
        st = e;
        rd(`DUIS_OFF_STATUS, {24'h0, e});
    endtask
    task automatic cmd(input logic [7:0] c);
        u_host.xfer(1'b1, `DUIS_OFF_COMMAND, {24'h0, c});
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic pulse(input logic [2:0] p);
        pls <= p;
        @(posedge hclk);
        pls <= 3'h0;
        settle(3);
    endtask
    task report_and_stop;
        errors = errors + u_host.hangs;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // read results checked at the data-phase edge
    // ------------------------------------------------------------------
    always @(posedge hclk) begin
        rd_ph <= hsel & hready & htrans[1] & ~hwrite;
        if (rd_ph) begin
            note = exp_q.pop_front();
            chk("hrdata", note[31:0], hrdata);
            chk("irq_out_n", {31'h0, note[32]}, {31'h0, irq_out_n});
            chk("hresp", 32'h0, {31'h0, hresp});
        end
    end
    initial begin
        settle(20000);
        errors++;
        report_and_stop();
    end
    initial begin
        hresetn = 1'b0;
        pls = 3'h0;
        rxl = 4'h0;
        txa = 5'h00;
        txb = 5'h00;
        st = 8'h00;
        mask = 8'h00;
        settle(3);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_st(8'h00);
        pulse(3'h1);
        rd_st(8'h04);
        rd_st(8'h04);
        pulse(3'h2);
        rd_st(8'h44);
        cmd(`DUIS_CMD_RST_BRK_A);
        rd_st(8'h40);
        cmd(`DUIS_CMD_RST_BRK_B);
        rd_st(8'h00);
        for (int i = 0; i < 4; i++) begin
            rxl <= 4'h1 << i;
            settle(3);
            rd_st(i[0] ? 8'h20 : 8'h02);
        end
        rxl <= 4'h0;
        settle(3);
        rd_st(8'h00);
        // threshold and one below on opposite channels
        for (int c = 0; c < 4; c++) begin
            u_host.xfer(1'b1, `DUIS_OFF_MODE_A, {26'h0, c[1:0], 4'h0});
            u_host.xfer(1'b1, `DUIS_OFF_MODE_B, {26'h0, c[1:0], 4'h0});
            txa <= thr[c];
            txb <= thr[c] - 5'h01;
            settle(3);
            rd_st(8'h01);
            txa <= thr[c] - 5'h01;
            txb <= thr[c];
            settle(3);
            rd_st(8'h10);
        end
        txb <= 5'h00;
        pulse(3'h4);
        rxl <= 4'h1;
        st = 8'h82;
        for (int k = 0; k < 4; k++) begin
            rnd = xs(rnd);
            mask = rnd[7:0];
            u_host.xfer(1'b1, `DUIS_OFF_MASK, {24'h0, mask});
            rd(`DUIS_OFF_MASK, {24'h0, mask});
            rd_st(8'h82);
        end
        u_host.xfer(1'b1, 12'h020, rnd);
        rd(12'h020, 32'h0);
        // the change read clears bit 7 at its address phase, before irq is seen
        st = 8'h02;
        rd(`DUIS_OFF_CHANGE, 32'h1);
        rd_st(8'h02);
        rxl <= 4'h0;
        u_host.xfer(1'b1, `DUIS_OFF_TIMER, 32'h2);
        cmd(`DUIS_CMD_START_CT);
        settle(20);
        rd_st(8'h08);
        cmd(`DUIS_CMD_STOP_CT);
        settle(20);
        rd_st(8'h00);
        u_host.xfer(1'b1, `DUIS_OFF_TIMER, 32'h10040);
        cmd(`DUIS_CMD_START_CT);
        settle(140);
        rd_st(8'h08);
        cmd(`DUIS_CMD_STOP_CT);
        rd_st(8'h00);
        // an odd zero count falls in this gap and must not set bit 3
        settle(60);
        rd_st(8'h00);
        settle(68);
        rd_st(8'h08);
        // reset in mid-run while bit 3 is set
        hresetn <= 1'b0;
        mask = 8'h00;
        settle(3);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_st(8'h00);
        // let the last data phase be compared before the verdict
        settle(2);
        if (exp_q.size() != 0) begin
            errors++;
            $display("BAD exp_q expected 0 seen %0d", exp_q.size());
        end
        report_and_stop();
    end
endmodule // duart_interrupt_status_tb
